// [rtl/afc_top.sv]
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.svh"
module afc_top #(
	parameter logic [5:0] NSH_CYC8 = 6'd40,
	parameter logic [5:0] NSH_CYC10 = 6'd50
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// trigger sources
	input wire logic ext_trig_pin,
	input wire logic tmr_b2_req,
	input wire logic tmr_a0_req,
	// analog front end
	input wire logic cmp_in,
	output logic [9:0] dac_code,
	output logic sampling,
	output logic [3:0] conv_src,
	output logic opamp_route,
	output logic [2:0] opamp_src,
	output logic ref_connect,
	output logic assist_pullup,
	output logic assist_pulldown,
	output logic assist_selftest,
	// transfer request
	output logic dma_req
);
	import afc_pkg::*;

	// whole controller state
	typedef struct packed {
		logic [2:0] ch;
		logic rpt;
		logic tsrc;
		logic start;
		logic res10;
		logic [1:0] ext;
		logic refc;
		logic sh;
		logic [1:0] tsel;
		logic [1:0] grp;
		logic dma;
		logic multiport_sweep_enable;
		logic aen;
		logic asel;
		logic amtd;
		logic [7:0][9:0] res;
		logic [15:0] rdata;
		logic ps1;
		logic ps2;
		logic ps3;
		logic [2:0] tgt;
		logic [3:0] src;
		logic opa;
		logic [2:0] opa_ch;
		logic dreq;
		logic pu;
		logic pd;
		logic stt;
	} afc_ctl_t;

	afc_ctl_t s;
	afc_ctl_t next_s;
	afc_sar_if sif ();

	logic wr0;
	logic stop;
	logic sw_go;
	logic hw_hit;
	logic hw_go;
	logic auto_go;
	logic go;
	logic [15:0] rd;

	// ----------------------------------------
	// converter engine
	// ----------------------------------------
	afc_sar_eng #(
		.NSH_CYC8(NSH_CYC8),
		.NSH_CYC10(NSH_CYC10)
	) u_eng (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.sif(sif)
	);

	// ----------------------------------------
	// start, trigger and stop decisions
	// ----------------------------------------
	always_comb begin
		wr0 = reg_wr && (reg_addr == `AFC_OFS_CTRL0);
		stop = wr0 && !reg_wdata[`AFC_C0_START] && s.start;
		sw_go = wr0 && reg_wdata[`AFC_C0_START] && !s.start
			&& !reg_wdata[`AFC_C0_TSRC];
		// pin edge is taken from the second and third sync stages
		unique case (s.tsel)
			`AFC_TS_PIN: hw_hit = s.ps3 && !s.ps2;
			`AFC_TS_TB2: hw_hit = tmr_b2_req;
			`AFC_TS_TA0: hw_hit = tmr_a0_req;
			default: hw_hit = 1'b0;
		endcase
		hw_go = s.start && s.tsrc && hw_hit;
		auto_go = sif.done && s.rpt && s.start && !stop;
		// a trigger while busy restarts the engine from sampling
		go = sw_go || hw_go || auto_go;
	end

	// engine command lines
	assign sif.start = go;
	assign sif.abort = stop;
	assign sif.res10 = s.res10;
	assign sif.sh_en = s.sh;
	assign sif.cmp = cmp_in;

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	always_comb begin
		rd = '0;
		if (reg_addr[`AFC_RES_BASE_BIT]) begin
			rd[9:0] = s.res[reg_addr[2:0]];
		end else begin
			unique case (reg_addr)
				`AFC_OFS_CTRL0: begin
					rd[`AFC_C0_CH +: 3] = s.ch;
					rd[`AFC_C0_RPT] = s.rpt;
					rd[`AFC_C0_TSRC] = s.tsrc;
					rd[`AFC_C0_START] = s.start;
				end
				`AFC_OFS_CTRL1: begin
					rd[`AFC_C1_RES] = s.res10;
					rd[`AFC_C1_EXT +: 2] = s.ext;
					rd[`AFC_C1_REFC] = s.refc;
				end
				`AFC_OFS_CTRL2: begin
					rd[`AFC_C2_SH] = s.sh;
					rd[`AFC_C2_TSEL +: 2] = s.tsel;
					rd[`AFC_C2_GRP +: 2] = s.grp;
				end
				`AFC_OFS_CTRL3: begin
					rd[`AFC_C3_DMA] = s.dma;
					rd[`AFC_C3_MSS] = s.multiport_sweep_enable;
				end
				`AFC_OFS_CTRL5: begin
					rd[`AFC_C5_AEN] = s.aen;
					rd[`AFC_C5_ASEL] = s.asel;
					rd[`AFC_C5_AMTD] = s.amtd;
				end
				`AFC_OFS_STATUS: begin
					rd[`AFC_ST_BUSY] = sif.busy;
					rd[`AFC_ST_START] = s.start;
				end
				default: rd = '0;
			endcase
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.rdata = reg_rd ? rd : '0;
		next_s.dreq = sif.done && s.dma;
		// pin passes two flops before the edge detector sees it
		next_s.ps1 = ext_trig_pin;
		next_s.ps2 = s.ps1;
		next_s.ps3 = s.ps2;
		// one-shot software conversion drops the start bit when done
		if (sif.done && !s.rpt && !s.tsrc) begin
			next_s.start = 1'b0;
		end
		// register writes; a write in the same clock wins over hardware
		if (reg_wr) begin
			unique case (reg_addr)
				`AFC_OFS_CTRL0: begin
					next_s.ch = reg_wdata[`AFC_C0_CH +: 3];
					next_s.rpt = reg_wdata[`AFC_C0_RPT];
					next_s.tsrc = reg_wdata[`AFC_C0_TSRC];
					next_s.start = reg_wdata[`AFC_C0_START];
				end
				`AFC_OFS_CTRL1: begin
					next_s.res10 = reg_wdata[`AFC_C1_RES];
					next_s.ext = reg_wdata[`AFC_C1_EXT +: 2];
					next_s.refc = reg_wdata[`AFC_C1_REFC];
				end
				`AFC_OFS_CTRL2: begin
					next_s.sh = reg_wdata[`AFC_C2_SH];
					next_s.tsel = reg_wdata[`AFC_C2_TSEL +: 2];
					next_s.grp = reg_wdata[`AFC_C2_GRP +: 2];
				end
				`AFC_OFS_CTRL3: begin
					next_s.dma = reg_wdata[`AFC_C3_DMA];
					next_s.multiport_sweep_enable = reg_wdata[`AFC_C3_MSS];
				end
				`AFC_OFS_CTRL5: begin
					next_s.aen = reg_wdata[`AFC_C5_AEN];
					next_s.asel = reg_wdata[`AFC_C5_ASEL];
					next_s.amtd = reg_wdata[`AFC_C5_AMTD];
				end
				default: begin
				end
			endcase
		end
		// routing latched at launch; the channel may come in the same write as start
		if (go) begin
			next_s.opa = 1'b0;
			next_s.opa_ch = next_s.ch;
			unique case (s.ext)
				`AFC_EXT_NONE: begin
					next_s.src = {1'b0, next_s.ch};
					next_s.tgt = next_s.ch;
				end
				`AFC_EXT_P0: begin
					next_s.src = `AFC_SRC_EXT0;
					next_s.tgt = 3'd0;
				end
				`AFC_EXT_P1: begin
					next_s.src = `AFC_SRC_EXT1;
					next_s.tgt = 3'd1;
				end
				`AFC_EXT_OPA: begin
					next_s.src = `AFC_SRC_EXT1;
					next_s.opa = 1'b1;
					next_s.tgt = next_s.ch;
				end
			endcase
			if (s.dma) begin
				next_s.tgt = 3'd0;
			end
		end
		// whole register loaded at once, upper bits cleared at 8 bits
		if (sif.done) begin
			next_s.res[s.tgt] = s.res10 ? sif.result
				: {2'b00, sif.result[7:0]};
		end
		// assist pull and purpose only while enabled
		next_s.pu = next_s.aen && !next_s.amtd;
		next_s.pd = next_s.aen && next_s.amtd;
		next_s.stt = next_s.aen && next_s.asel;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = s.rdata;
	assign dac_code = sif.trial;
	assign sampling = sif.sampling;
	assign conv_src = s.src;
	assign opamp_route = s.opa;
	assign opamp_src = s.opa_ch;
	assign ref_connect = s.refc;
	assign assist_pullup = s.pu;
	assign assist_pulldown = s.pd;
	assign assist_selftest = s.stt;
	assign dma_req = s.dreq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	property p_sw_start;
		sw_go |=> sif.busy && sif.sampling;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start lost");

	property p_pin_edge;
		(s.start && s.tsrc && s.tsel == `AFC_TS_PIN && s.ps3 && !s.ps2)
			|=> sif.sampling;
	endproperty
	a_pin_edge: assert property (p_pin_edge) else $error("pin edge ignored");

	property p_tmr_b2;
		(s.start && s.tsrc && s.tsel == `AFC_TS_TB2 && tmr_b2_req) |=> sif.sampling;
	endproperty
	a_tmr_b2: assert property (p_tmr_b2) else $error("timer trigger ignored");

	property p_ignore;
		(!s.start && !wr0 && !sif.busy) |=> !sif.busy;
	endproperty
	a_ignore: assert property (p_ignore) else $error("started while not armed");

	property p_restart;
		(hw_go && sif.busy && !sif.sampling) |=> sif.sampling;
	endproperty
	a_restart: assert property (p_restart) else $error("retrigger not restarted");

	property p_stop;
		(wr0 && !reg_wdata[`AFC_C0_START] && !hw_go) |=> !sif.busy;
	endproperty
	a_stop: assert property (p_stop) else $error("conversion not stopped");

	property p_dma_dst;
		(sif.done && s.dma && s.res10) |=> s.res[0] == $past(sif.result);
	endproperty
	a_dma_dst: assert property (p_dma_dst) else $error("dma result misplaced");

	property p_dma_req;
		(sif.done && s.dma) |=> dma_req ##1 !dma_req;
	endproperty
	a_dma_req: assert property (p_dma_req) else $error("dma request wrong");

	property p_res8;
		(sif.done && !s.res10) |=> s.res[$past(s.tgt)][9:8] == 2'b00;
	endproperty
	a_res8: assert property (p_res8) else $error("upper bits not zero");

	property p_opamp;
		(go && s.ext == `AFC_EXT_OPA)
			|=> conv_src == `AFC_SRC_EXT1 && opamp_route && opamp_src == $past(next_s.ch);
	endproperty
	a_opamp: assert property (p_opamp) else $error("op-amp routing wrong");

	property p_assist;
		!s.aen |-> !assist_pullup && !assist_pulldown && !assist_selftest;
	endproperty
	a_assist: assert property (p_assist) else $error("assist active while off");

	c_sw_done: cover property (sw_go ##[1:60] sif.done);
	c_retrig: cover property (hw_go && sif.busy);
	c_dma: cover property (sif.done && s.dma ##1 dma_req);
endmodule // afc_top
`default_nettype wire

// [rtl/afc_map.svh]
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH
// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define AFC_OFS_CTRL0 4'h0
`define AFC_OFS_CTRL1 4'h1
`define AFC_OFS_CTRL2 4'h2
`define AFC_OFS_CTRL3 4'h3
`define AFC_OFS_CTRL5 4'h5
`define AFC_OFS_STATUS 4'h6
`define AFC_RES_BASE_BIT 3
// ----------------------------------------
// field positions
// ----------------------------------------
`define AFC_C0_CH 0
`define AFC_C0_RPT 3
`define AFC_C0_TSRC 4
`define AFC_C0_START 5
`define AFC_C1_RES 0
`define AFC_C1_EXT 1
`define AFC_C1_REFC 3
`define AFC_C2_SH 0
`define AFC_C2_TSEL 1
`define AFC_C2_GRP 3
`define AFC_C3_DMA 0
`define AFC_C3_MSS 1
`define AFC_C5_AEN 0
`define AFC_C5_ASEL 1
`define AFC_C5_AMTD 2
`define AFC_ST_BUSY 0
`define AFC_ST_START 1
// ----------------------------------------
// selector codes
// ----------------------------------------
`define AFC_TS_PIN 2'h0
`define AFC_TS_TB2 2'h1
`define AFC_TS_TA0 2'h2
`define AFC_EXT_NONE 2'h0
`define AFC_EXT_P0 2'h1
`define AFC_EXT_P1 2'h2
`define AFC_EXT_OPA 2'h3
`define AFC_SRC_EXT0 4'h8
`define AFC_SRC_EXT1 4'h9
// ----------------------------------------
// timing in converter clocks, and the top trial bit for each resolution
// ----------------------------------------
`define AFC_SH_CYC8 6'd28
`define AFC_SH_CYC10 6'd33
`define AFC_SAMP_SH 6'd3
`define AFC_SAMP_NSH 6'd2
`define AFC_MSB10 4'd9
`define AFC_MSB8 4'd7
`endif

// [rtl/afc_pkg.sv]
package afc_pkg;
	// converter engine phases
	typedef enum logic [1:0] {S_IDLE, S_SAMP, S_TRIAL, S_WAIT} afc_phase_t;

	typedef struct packed {
		afc_phase_t st;
		logic [5:0] cnt;
		logic [3:0] bidx;
		logic res10;
		logic sh;
		logic [9:0] code;
		logic [9:0] trial;
		logic [9:0] result;
		logic done;
	} afc_sar_t;
endpackage

// [rtl/afc_sar_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface afc_sar_if;
	logic start;
	logic abort;
	logic res10;
	logic sh_en;
	logic cmp;
	logic busy;
	logic sampling;
	logic done;
	logic [9:0] result;
	logic [9:0] trial;
	modport ctl (output start, abort, res10, sh_en, cmp,
		input busy, sampling, done, result, trial);
	modport eng (input start, abort, res10, sh_en, cmp,
		output busy, sampling, done, result, trial);
endinterface
`default_nettype wire

// [rtl/afc_sar_eng.sv]
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.svh"
module afc_sar_eng #(
	parameter logic [5:0] NSH_CYC8 = 6'd40,
	parameter logic [5:0] NSH_CYC10 = 6'd50
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// controller side
	afc_sar_if.eng sif
);
	import afc_pkg::*;

	afc_sar_t s;
	afc_sar_t next_s;
	logic [5:0] total;
	logic [5:0] samp;

	// sampling plus trials must fit inside the shortest conversion
	if (NSH_CYC8 < 6'd11 || NSH_CYC10 < 6'd13) begin : g_chk
		$error("afc_sar_eng: conversion length too short");
	end

	// ----------------------------------------
	// successive approximation sequence
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		total = s.sh ? (s.res10 ? `AFC_SH_CYC10 : `AFC_SH_CYC8)
			: (s.res10 ? NSH_CYC10 : NSH_CYC8);
		samp = s.sh ? `AFC_SAMP_SH : `AFC_SAMP_NSH;
		if (s.st != S_IDLE) begin
			next_s.cnt = s.cnt + 6'd1;
		end
		unique case (s.st)
			S_IDLE: begin
			end
			S_SAMP: begin
				if (s.cnt == samp - 6'd1) begin
					next_s.st = S_TRIAL;
				end
			end
			S_TRIAL: begin
				if (sif.cmp) begin
					next_s.code[s.bidx] = 1'b1;
				end
				if (s.bidx == 4'd0) begin
					next_s.st = S_WAIT;
				end else begin
					next_s.bidx = s.bidx - 4'd1;
				end
			end
			S_WAIT: begin
				if (s.cnt == total - 6'd1) begin
					next_s.st = S_IDLE;
					next_s.done = 1'b1;
					next_s.result = s.code;
				end
			end
		endcase
		// a new start wins over abort and restarts from zero
		if (sif.start) begin
			next_s.st = S_SAMP;
			next_s.cnt = '0;
			next_s.code = '0;
			next_s.res10 = sif.res10;
			next_s.sh = sif.sh_en;
			next_s.bidx = sif.res10 ? `AFC_MSB10 : `AFC_MSB8;
		end else if (sif.abort) begin
			next_s.st = S_IDLE;
		end
		// trial code held in a flop for the ladder
		next_s.trial = next_s.code;
		if (next_s.st == S_TRIAL) begin
			next_s.trial[next_s.bidx] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs to the controller
	assign sif.busy = (s.st != S_IDLE);
	assign sif.sampling = (s.st == S_SAMP);
	assign sif.done = s.done;
	assign sif.result = s.result;
	assign sif.trial = s.trial;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_len_sh8;
		@(posedge sys_clk) disable iff (!arst_n)
		(s.done && s.sh && !s.res10) |-> $past(s.cnt) == `AFC_SH_CYC8 - 6'd1;
	endproperty
	a_len_sh8: assert property (p_len_sh8) else $error("wrong 8-bit length");

	property p_len_sh10;
		@(posedge sys_clk) disable iff (!arst_n)
		(s.done && s.sh && s.res10) |-> $past(s.cnt) == `AFC_SH_CYC10 - 6'd1;
	endproperty
	a_len_sh10: assert property (p_len_sh10) else $error("wrong 10-bit length");

	property p_samp_len;
		@(posedge sys_clk) disable iff (!arst_n)
		(s.st == S_TRIAL && $past(s.st) == S_SAMP && !$past(sif.start))
			|-> $past(s.cnt) == (s.sh ? `AFC_SAMP_SH : `AFC_SAMP_NSH) - 6'd1;
	endproperty
	a_samp_len: assert property (p_samp_len) else $error("wrong sample time");
endmodule // afc_sar_eng
`default_nettype wire

// [rtl/afc_note_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/afc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: comparator on a held level, dma controller
// ----------------------------------------
module afc_far_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// analog side
	input wire logic [9:0] level,
	input wire logic res10,
	input wire logic [9:0] dac_code,
	output logic cmp_in,
	// dma side
	input wire logic dma_req,
	output int xfers,
	output int xfer_bits
);
	// 8-bit trials compare against the top eight bits of the level
	always_comb begin
		cmp_in = res10 ? (level >= dac_code) : (level[9:2] >= dac_code[7:0]);
	end
	// one transfer per request, unit width follows resolution
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			xfers <= 0;
			xfer_bits <= 0;
		end else if (dma_req) begin
			xfers <= xfers + 1;
			xfer_bits <= res10 ? 16 : 8;
		end
	end
endmodule // afc_far_model
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import afc_pkg::*;
	localparam logic [5:0] NSH8 = 6'd40;
	localparam logic [5:0] NSH10 = 6'd50;
	typedef struct packed {
		logic r10; logic sh; logic dma; logic [1:0] ext; logic [2:0] ch;
		logic [9:0] lvl; logic [3:0] idx; logic [9:0] res; logic [3:0] src;
	} afc_row_t;
	logic sys_clk = 0;
	logic arst_n = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [15:0] reg_rdata;
	logic ext_trig_pin = 0;
	logic tmr_b2_req = 0;
	logic tmr_a0_req = 0;
	logic cmp_in, sampling, opamp_route, ref_connect, dma_req;
	logic assist_pullup, assist_pulldown, assist_selftest;
	logic [9:0] dac_code;
	logic [3:0] conv_src;
	logic [2:0] opamp_src;
	logic [9:0] level = 10'h000;
	logic res10_m = 0;
	int xfers, xfer_bits;
	int miscompares = 0;
	int checks = 0;
	int t = 0, nsamp = 0, tot = 0, starts = 0, n, k, tt;
	logic samp_q = 0;
	logic [3:0] src_seen = 4'h0;
	logic opa_seen = 0;
	logic [2:0] ops_seen = 3'h0;
	logic [15:0] d;
	afc_row_t row;
	// ordinary conversions, software start
	afc_row_t rows [7] = '{
		'{1'h1, 1'h1, 1'h0, 2'h0, 3'h3, 10'h3A5, 4'hB, 10'h3A5, 4'h3},
		'{1'h0, 1'h1, 1'h1, 2'h0, 3'h5, 10'h3A5, 4'h8, 10'h0E9, 4'h5},
		'{1'h1, 1'h0, 1'h0, 2'h1, 3'h0, 10'h0FF, 4'h8, 10'h0FF, 4'h8},
		'{1'h0, 1'h0, 1'h1, 2'h2, 3'h2, 10'h200, 4'h8, 10'h080, 4'h9},
		'{1'h1, 1'h1, 1'h0, 2'h3, 3'h6, 10'h155, 4'hE, 10'h155, 4'h9},
		'{1'h1, 1'h1, 1'h1, 2'h2, 3'h4, 10'h3FF, 4'h8, 10'h3FF, 4'h9},
		'{1'h0, 1'h0, 1'h0, 2'h1, 3'h1, 10'h2C0, 4'h8, 10'h0B0, 4'h8}};

	always #20 sys_clk = ~sys_clk;

	afc_top #(.NSH_CYC8(NSH8), .NSH_CYC10(NSH10)) u_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_trig_pin(ext_trig_pin), .tmr_b2_req(tmr_b2_req), .tmr_a0_req(tmr_a0_req),
		.cmp_in(cmp_in), .dac_code(dac_code), .sampling(sampling), .conv_src(conv_src),
		.opamp_route(opamp_route), .opamp_src(opamp_src), .ref_connect(ref_connect),
		.assist_pullup(assist_pullup), .assist_pulldown(assist_pulldown),
		.assist_selftest(assist_selftest), .dma_req(dma_req));

	// assist pulls drive the converted input to a rail
	afc_far_model u_far (.sys_clk(sys_clk), .arst_n(arst_n), .res10(res10_m),
		.level(assist_pullup ? 10'h3FF : (assist_pulldown ? 10'h000 : level)),
		.dac_code(dac_code), .cmp_in(cmp_in), .dma_req(dma_req), .xfers(xfers),
		.xfer_bits(xfer_bits));

	// ----------------------------------------
	// monitor: sampling length, starts, time to transfer request
	// ----------------------------------------
	// pre-edge values are read, so counts never race the design's updates
	always @(posedge sys_clk) begin
		samp_q <= sampling;
		t <= t + 1;
		if (sampling && !samp_q) begin
			t <= 0;
			nsamp <= 1;
			starts <= starts + 1;
		end else if (sampling) begin
			nsamp <= nsamp + 1;
		end
		if (sampling) begin
			src_seen <= conv_src;
			opa_seen <= opamp_route;
			ops_seen <= opamp_src;
		end
		if (dma_req) begin
			tot <= t;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge sys_clk);
		reg_rd <= 0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask
	// poll status until the busy bit drops, bounded
	task automatic wait_idle();
		logic [15:0] s;
		s = 16'h0001;
		for (int i = 0; i < 100 && s[0] !== 1'b0; i++) rd(4'h6, s);
	endtask
	// pin needs a rise then a fall: its synchroniser starts low and the detector fires on the fall
	// timer requests are one-clock pulses
	task automatic fire(input int s);
		@(posedge sys_clk);
		ext_trig_pin <= (s == 0);
		tmr_b2_req <= (s == 1);
		tmr_a0_req <= (s == 2);
		@(posedge sys_clk);
		tmr_b2_req <= 0;
		tmr_a0_req <= 0;
		repeat (2) @(posedge sys_clk);
		ext_trig_pin <= 0;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// whole run is well under 20k cycles
	initial begin
		#(40 * 60000);
		miscompares++;
		wrap_up();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("reset_outs", 16'h0000, {2'h0, dma_req, sampling, ref_connect, opamp_route, dac_code});
		@(posedge sys_clk);
		arst_n <= 1;
		// read-only and unmapped places ignore writes
		wr(4'h4, 16'hFFFF);
		wr(4'h6, 16'hFFFF);
		wr(4'h8, 16'hFFFF);
		for (int i = 0; i < 16; i++) begin
			rd(i[3:0], d);
			chk("reset_reg", 16'h0000, d);
		end
		// assist: every enable, purpose and pull combination
		for (int i = 0; i < 8; i++) begin
			wr(4'h5, 16'(i));
			rd(4'h5, d);
			chk("assist_reg", 16'(i), d);
			chk("assist", i[0] ? {13'h0, ~i[2], i[2], i[1]} : 16'h0000,
				{13'h0, assist_pullup, assist_pulldown, assist_selftest});
		end
		wr(4'h5, 16'h0000);
		foreach (rows[i]) begin
			row = rows[i];
			level <= row.lvl;
			res10_m <= row.r10;
			n = xfers;
			wr(4'h1, {12'h0, 1'h1, row.ext, row.r10});
			wr(4'h2, {15'h0, row.sh});
			wr(4'h3, {15'h0, row.dma});
			repeat (26) @(posedge sys_clk);
			chk("ref", 16'h0001, {15'h0, ref_connect});
			wr(4'h0, {10'h0, 3'h4, row.ch});
			wait_idle();
			rd(row.idx, d);
			chk("result", {6'h00, row.res}, d);
			chk("src", {12'h0, row.src}, {12'h0, src_seen});
			chk("opamp", {12'h0, row.ext == 2'h3, 3'h0}, {12'h0, opa_seen, 3'h0});
			if (row.ext == 2'h3) chk("opsrc", {13'h0, row.ch}, {13'h0, ops_seen});
			chk("samp", row.sh ? 16'd3 : 16'd2, 16'(nsamp));
			chk("xfers", 16'(n + row.dma), 16'(xfers));
			if (row.dma) begin
				tt = row.r10 ? (row.sh ? 33 : NSH10) : (row.sh ? 28 : NSH8);
				// request comes with the store, one clock after done, so the gap equals the length
				chk("total", 16'(tt), 16'(tot));
				// the result must fit inside the unit the controller moves
				chk("width", 16'h0000, d >> xfer_bits);
			end
		end
		// self test: pull-up must read full scale, pull-down zero
		for (int i = 0; i < 2; i++) begin
			wr(4'h5, i ? 16'h0007 : 16'h0003);
			wr(4'h0, 16'h0021);
			wait_idle();
			rd(4'h8, d);
			chk("selftest", i ? 16'h0000 : 16'h00FF, d);
		end
		wr(4'h5, 16'h0000);
		// hardware triggers, refused sources, retrigger
		level <= 10'h2A7;
		res10_m <= 1;
		wr(4'h1, 16'h0009);
		wr(4'h3, 16'h0001);
		for (int s = 0; s < 3; s++) begin
			wr(4'h0, 16'h0000);
			wr(4'h2, {13'h0, s[1:0], 1'h1});
			n = starts;
			wr(4'h0, 16'h0010);
			for (int o = 0; o < 3; o++) fire(o);
			chk("disarmed", 16'(n), 16'(starts));
			wr(4'h0, 16'h0030);
			for (int o = 0; o < 3; o++) if (o != s) fire(o);
			chk("wrong_src", 16'(n), 16'(starts));
			fire(s);
			chk("hw_start", 16'(n + 1), 16'(starts));
			k = xfers;
			fire(s);
			chk("restart", 16'(n + 2), 16'(starts));
			for (int w = 0; w < 200 && xfers == k; w++) @(posedge sys_clk);
			chk("re_xfer", 16'(k + 1), 16'(xfers));
			chk("re_total", 16'd33, 16'(tot));
			rd(4'h8, d);
			chk("re_result", 16'h02A7, d);
		end
		// repeat bit: each finish launches the next conversion by itself
		wr(4'h0, 16'h0000);
		n = starts;
		k = xfers;
		wr(4'h0, 16'h0028);
		repeat (80) @(posedge sys_clk);
		// stop by clearing start in mid-conversion
		wr(4'h0, 16'h0000);
		chk("repeat", 16'(n + 3), 16'(starts));
		chk("rpt_xfer", 16'(k + 2), 16'(xfers));
		wr(4'h0, 16'h0020);
		repeat (10) @(posedge sys_clk);
		wr(4'h0, 16'h0000);
		n = xfers;
		repeat (40) @(posedge sys_clk);
		chk("stop_xfer", 16'(n), 16'(xfers));
		rd(4'h6, d);
		chk("stop_status", 16'h0000, d);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
